// >>> sosc_edge_if.sv
`timescale 1ns/1ps
interface sosc_edge_if;
  logic sel;
  logic rise;
  logic fall;
  logic sdi;
  logic cs_fall;
  logic cs_rise;
  modport src (output sel, output rise, output fall, output sdi, output cs_fall, output cs_rise);
  modport dst (input sel, input rise, input fall, input sdi, input cs_fall, input cs_rise);
endinterface : sosc_edge_if

// >>> sosc_master.sv
`timescale 1ns/1ps
// ==========================================================
// Serial master model driving the select, clock and data pins
module sosc_master (
  // Serial pins
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_sdi,
  input wire logic i_sdo,
  input wire logic i_sdo_oe_n,
  // What the serial output showed
  output logic [31:0] o_seen,
  output logic o_driven
);
  // Idle: deselected with the clock parked high
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_sdi = 1'b0;
    o_seen = 32'h0;
    o_driven = 1'b1;
  end
  // One frame of n bits, top bit first, half period in ns
  task automatic frame(input logic [31:0] data, input int n, input int half);
    o_seen = 32'h0;
    o_driven = 1'b1;
    #(half + 7) o_cs_n = 1'b0;
    #(half);
    for (int k = n - 1; k >= 0; k--) begin
      o_sclk = 1'b0;
      o_sdi = data[k];
      #(half) o_sclk = 1'b1;
      #(half) o_seen = {o_seen[30:0], i_sdo_oe_n ? ~i_sdo : i_sdo}; // Released line reads as garbage
      o_driven = o_driven & ~i_sdo_oe_n;
    end
    o_cs_n = 1'b1;
    #(half) o_sdi = ~o_sdi;
  endtask : frame
  // Clock and data activity while deselected
  task automatic wiggle(input int n);
    repeat (n) begin
      #43 o_sclk = 1'b0;
      o_sdi = ~o_sdi;
      #43 o_sclk = 1'b1;
    end
  endtask : wiggle
endmodule : sosc_master

// >>> sosc_pkg.sv
package sosc_pkg;
  // ==========================================================
  // Frame and channel layout
  localparam int CHANNELS = 8;
  localparam int FRAME_BITS = 8;
  localparam int CNT_W = 3;
  localparam logic [CHANNELS-1:0] OUTPUTS_RESET = 8'h00;
  localparam logic [CHANNELS-1:0] SHIFT_RESET = 8'h00;
  // ==========================================================
  // Rejection limit and thermal restart timing
  localparam int REJECT_LIMIT = 4;
  localparam logic [2:0] REJECT_LIMIT_3 = 3'h4;
  localparam int CLK_MHZ = 50;
  localparam int PWM_ON_US = 100;
  localparam int PWM_PERIOD_US = 1000;
  localparam int PWM_ON_CYC = PWM_ON_US * CLK_MHZ;
  localparam int PWM_PERIOD_CYC = PWM_PERIOD_US * CLK_MHZ;
endpackage : sosc_pkg

// >>> sosc_sync.sv
`timescale 1ns/1ps
module sosc_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Raw pins
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_sdi,
  // Synchronised events
  sosc_edge_if.src ev
);
  // ==========================================================
  // Two-stage synchronisers plus one history stage
  logic [2:0] s1, s2, s3;
  logic [2:0] next_s1, next_s2, next_s3;
  always_comb begin
    next_s1 = {i_cs_n, i_sclk, i_sdi};
    next_s2 = s1;
    next_s3 = s2;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1 <= 3'h6;
      s2 <= 3'h6;
      s3 <= 3'h6;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
    end
  end
  // Edges taken only from second and third stages
  assign ev.sel = ~s2[2];
  assign ev.sdi = s2[0];
  assign ev.rise = ~s2[2] & s2[1] & ~s3[1];
  assign ev.fall = ~s2[2] & ~s2[1] & s3[1];
  assign ev.cs_fall = ~s2[2] & s3[2];
  assign ev.cs_rise = s2[2] & ~s3[2];
endmodule : sosc_sync

// >>> sosc_thermal.sv
`timescale 1ns/1ps
module sosc_thermal
  import sosc_pkg::*;
#(
  parameter int ON_CYC = PWM_ON_CYC,
  parameter int PERIOD_CYC = PWM_PERIOD_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Channel request and temperature
  input wire logic i_req,
  input wire logic i_hot,
  // Gated drive
  output logic o_drive
);
  // ==========================================================
  // Low duty restart cycle while hot
  logic [31:0] cnt, next_cnt;
  always_comb begin
    next_cnt = cnt;
    if (!i_hot) next_cnt = 32'h0;
    else if (cnt >= 32'(PERIOD_CYC - 1)) next_cnt = 32'h0;
    else next_cnt = cnt + 32'h1;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) cnt <= 32'h0;
    else cnt <= next_cnt;
  end
  // Hot channel only drives in short restart window
  assign o_drive = i_req & (~i_hot | (cnt < 32'(ON_CYC)));
endmodule : sosc_thermal

// >>> sosc_top.sv
`timescale 1ns/1ps
module sosc_top
  import sosc_pkg::*;
#(
  parameter int ON_CYC = PWM_ON_CYC,
  parameter int PERIOD_CYC = PWM_PERIOD_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Serial pins
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe_n,
  // Control and status pins
  input wire logic i_output_disable_n,
  input wire logic [CHANNELS-1:0] i_overtemp,
  input wire logic i_supply_low,
  output logic [CHANNELS-1:0] o_switch_outputs,
  output logic o_common_fault_flag_n,
  output logic o_common_fault_flag_oe_n
);
  // ==========================================================
  // Pin synchronisers for asynchronous status inputs
  logic [CHANNELS+1:0] st1, st2;
  logic [CHANNELS+1:0] next_st1, next_st2;
  // Next stage values; reset shows disable released and supply good, so no false fault follows reset
  always_comb begin
    next_st1 = {i_output_disable_n, i_supply_low, i_overtemp};
    next_st2 = st1;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st1 <= {2'h2, {CHANNELS{1'b0}}};
      st2 <= {2'h2, {CHANNELS{1'b0}}};
    end else begin
      st1 <= next_st1;
      st2 <= next_st2;
    end
  end
  logic dis_act;
  logic [CHANNELS-1:0] hot;
  logic uv;
  assign dis_act = ~st2[CHANNELS+1];
  assign uv = st2[CHANNELS];
  assign hot = st2[CHANNELS-1:0];

  // ==========================================================
  // Serial event extraction
  sosc_edge_if ev ();
  sosc_sync u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_cs_n(i_cs_n),
    .i_sclk(i_sclk),
    .i_sdi(i_sdi),
    .ev(ev)
  );

  // ==========================================================
  // Shift register, counter, latch and rejection state
  logic [FRAME_BITS-1:0] shreg, next_shreg;
  logic [CNT_W-1:0] bitcnt, next_bitcnt;
  logic any_clk, next_any_clk;
  logic [CHANNELS-1:0] latch, next_latch;
  logic [2:0] rejects, next_rejects;
  logic forced_off, next_forced_off;
  logic sdo, next_sdo;
  logic sdo_oe_n, next_sdo_oe_n;
  logic valid;
  // is relied on: select edges occur with clock high, so no false edge is seen
  assign valid = any_clk & (bitcnt == '0); // Multiple of 8, zero clocks is not valid
  always_comb begin
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_any_clk = any_clk;
    next_latch = latch;
    next_rejects = rejects;
    next_forced_off = forced_off;
    next_sdo = sdo;
    next_sdo_oe_n = sdo_oe_n;
    if (dis_act) begin
      next_shreg = SHIFT_RESET; // Disable clears registers
      next_bitcnt = '0;
      next_any_clk = 1'b0;
      next_latch = OUTPUTS_RESET; // Outputs off until new data
      next_rejects = 3'h0;
      next_forced_off = 1'b0;
      next_sdo_oe_n = 1'b1;
    end else if (ev.cs_fall) begin
      next_bitcnt = '0;
      next_any_clk = 1'b0;
      next_sdo = shreg[FRAME_BITS-1]; // Drive current top bit
      next_sdo_oe_n = 1'b0;
    end else if (ev.cs_rise) begin
      next_sdo_oe_n = 1'b1; // Release output
      if (valid) begin
        next_latch = shreg; // Bit 7 to channel 7
        next_rejects = 3'h0;
        next_forced_off = 1'b0;
      end else begin
        if (rejects < REJECT_LIMIT_3) next_rejects = rejects + 3'h1;
        if (rejects + 3'h1 >= REJECT_LIMIT_3) next_forced_off = 1'b1;
      end
    end else if (ev.sel) begin
      if (ev.rise) begin
        next_shreg = {shreg[FRAME_BITS-2:0], ev.sdi}; // MSB first
        next_bitcnt = bitcnt + 3'h1; // Modulo 8 count
        next_any_clk = 1'b1;
      end
      if (ev.fall) next_sdo = shreg[FRAME_BITS-1]; // Advance after falling edge
    end else begin
      next_sdo_oe_n = 1'b1; // Deselected: ignore pins, release output
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      shreg <= SHIFT_RESET;
      bitcnt <= '0;
      any_clk <= 1'b0;
      latch <= OUTPUTS_RESET;
      rejects <= 3'h0;
      forced_off <= 1'b0;
      sdo <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else begin
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      any_clk <= next_any_clk;
      latch <= next_latch;
      rejects <= next_rejects;
      forced_off <= next_forced_off;
      sdo <= next_sdo;
      sdo_oe_n <= next_sdo_oe_n;
    end
  end

  // ==========================================================
  // Per-channel thermal restart
  logic [CHANNELS-1:0] drive;
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      sosc_thermal #(
        .ON_CYC(ON_CYC),
        .PERIOD_CYC(PERIOD_CYC)
      ) u_th (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_req(latch[g]),
        .i_hot(hot[g]),
        .o_drive(drive[g])
      );
    end
  endgenerate

  // ==========================================================
  // Registered outputs
  logic [CHANNELS-1:0] next_out;
  logic next_fault_n;
  always_comb begin
    next_out = (dis_act | forced_off) ? OUTPUTS_RESET : drive; // One drives, zero off
    next_fault_n = ~((|hot) | uv); // OR-ed fault, low active
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_switch_outputs <= OUTPUTS_RESET;
      o_common_fault_flag_n <= 1'b1;
      o_common_fault_flag_oe_n <= 1'b1;
      o_sdo <= 1'b0;
      o_sdo_oe_n <= 1'b1;
    end else begin
      o_switch_outputs <= next_out;
      o_common_fault_flag_n <= next_fault_n;
      o_common_fault_flag_oe_n <= next_fault_n; // Open drain pulls low only on fault
      o_sdo <= next_sdo;
      o_sdo_oe_n <= next_sdo_oe_n;
    end
  end

  // ==========================================================
  // Assertions on the serial output
  // Output stays released while deselected
  a_sdo_released: assert property (@(posedge i_clk) disable iff (i_rst)
    (st2[CHANNELS+1] && $past(ev.sel) == 1'b0) |-> o_sdo_oe_n)
    else $error("serial output driven while deselected");
  // Select low drives the output on the next cycle
  a_sdo_driven: assert property (@(posedge i_clk) disable iff (i_rst)
    (ev.cs_fall && !dis_act) |=> !o_sdo_oe_n)
    else $error("serial output not driven after select");
  // First bit shown is the current top bit
  a_start_bit: assert property (@(posedge i_clk) disable iff (i_rst)
    (ev.cs_fall && !dis_act) |=> o_sdo == $past(shreg[FRAME_BITS-1]))
    else $error("first serial output bit wrong");
  // Select high releases the output
  a_rise_release: assert property (@(posedge i_clk) disable iff (i_rst)
    (ev.cs_rise) |=> o_sdo_oe_n)
    else $error("serial output not released");
  // Falling clock advances to the next top bit
  a_sdo_advance: assert property (@(posedge i_clk) disable iff (i_rst)
    (ev.sel && ev.fall && !dis_act) |=> o_sdo == $past(shreg[FRAME_BITS-1]))
    else $error("serial output did not advance");
  // Output bit holds between falling clocks
  a_sdo_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (ev.sel && !ev.fall && !ev.cs_fall && !dis_act) |=> $stable(o_sdo))
    else $error("serial output changed without falling clock");

  // ==========================================================
  // Assertions on framing and latching
  // Rising clock shifts the input bit in
  a_shift_in: assert property (@(posedge i_clk) disable iff (i_rst)
    (ev.sel && ev.rise && !ev.cs_fall && !dis_act) |=> shreg[0] == $past(ev.sdi))
    else $error("input bit not shifted in");
  // Register moves only on a rising clock while selected
  a_shift_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (!dis_act && !(ev.sel && ev.rise)) |=> $stable(shreg))
    else $error("shift register moved without clock");
  // Each rising clock advances the modulo count
  a_count_step: assert property (@(posedge i_clk) disable iff (i_rst)
    (ev.sel && ev.rise && !ev.cs_fall && !dis_act) |=> bitcnt == $past(bitcnt) + 3'h1)
    else $error("clock count did not advance");
  // Select low restarts the count
  a_count_restart: assert property (@(posedge i_clk) disable iff (i_rst)
    (ev.cs_fall && !dis_act) |=> (bitcnt == '0 && !any_clk))
    else $error("clock count not restarted");
  // Clock and data are ignored while deselected
  a_ignore_deselect: assert property (@(posedge i_clk) disable iff (i_rst)
    (!ev.sel && !ev.cs_rise && !dis_act) |=> ($stable(latch) && $stable(bitcnt)))
    else $error("deselected activity changed state");
  // Valid frame is copied into the latch
  a_latch_valid: assert property (@(posedge i_clk) disable iff (i_rst)
    (ev.cs_rise && valid && !dis_act) |=> latch == $past(shreg))
    else $error("valid frame not latched");
  // Latch changes only on a rising select
  a_latch_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (!ev.cs_rise && !dis_act) |=> $stable(latch))
    else $error("latch changed without rising select");
  // Rejected frame keeps the latch
  a_latch_keep: assert property (@(posedge i_clk) disable iff (i_rst)
    (ev.cs_rise && !valid && !dis_act) |=> $stable(latch))
    else $error("rejected frame changed outputs");
  // Rejected frame advances the reject count
  a_reject_count: assert property (@(posedge i_clk) disable iff (i_rst)
    (ev.cs_rise && !valid && !dis_act && rejects < REJECT_LIMIT_3) |=> rejects == $past(rejects) + 3'h1)
    else $error("reject count did not advance");
  // Accepted frame clears the count and the forced off state
  a_accept_clears: assert property (@(posedge i_clk) disable iff (i_rst)
    (ev.cs_rise && valid && !dis_act) |=> (rejects == 3'h0 && !forced_off))
    else $error("accepted frame did not clear rejects");
  // Fourth reject in a row forces the outputs off
  a_fourth_reject: assert property (@(posedge i_clk) disable iff (i_rst)
    (ev.cs_rise && !valid && !dis_act && rejects == REJECT_LIMIT_3 - 3'h1) |=> forced_off)
    else $error("fourth reject did not force outputs off");

  // ==========================================================
  // Assertions on the switch outputs and fault flag
  // Forced off state blanks every output
  a_reject_off: assert property (@(posedge i_clk) disable iff (i_rst)
    (forced_off) |=> o_switch_outputs == OUTPUTS_RESET)
    else $error("outputs on after four rejects");
  // Disable blanks outputs and latch
  a_disable_off: assert property (@(posedge i_clk) disable iff (i_rst)
    (dis_act) |=> (o_switch_outputs == OUTPUTS_RESET && latch == OUTPUTS_RESET))
    else $error("outputs not off under disable");
  // Disable clears the input registers and reject state
  a_disable_regs: assert property (@(posedge i_clk) disable iff (i_rst)
    (dis_act) |=> (shreg == SHIFT_RESET && rejects == 3'h0 && !forced_off && o_sdo_oe_n))
    else $error("registers not cleared under disable");
  // Cool channels follow their latch bit whatever hot channels do
  a_cool_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    (!dis_act && !forced_off) |=> ((o_switch_outputs & ~$past(hot)) == ($past(latch) & ~$past(hot))))
    else $error("cool channel output differs from latch");
  // Any fault pulls the flag low
  a_fault_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    ((|hot) || uv) |=> !o_common_fault_flag_n)
    else $error("fault flag not low on fault");
  // No fault keeps the flag high
  a_fault_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    (!(|hot) && !uv) |=> o_common_fault_flag_n)
    else $error("fault flag low without fault");
endmodule : sosc_top

// >>> sosc_top_bench.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the switch control block
module sosc_top_bench;
  import sosc_pkg::*;
  localparam int ON_T = 4;
  localparam int PER_T = 16;
  logic i_clk, i_rst, cs_n, sclk, sdi, sdo, sdo_oe_n, dis_n, supply_low, flag_n, flag_oe_n, driven;
  logic [CHANNELS-1:0] overtemp, outs, exp_out, sreg;
  logic [31:0] seen, rng;
  int num_errors, compares, rejects, cnt;
  // Device and master
  sosc_top #(.ON_CYC(ON_T), .PERIOD_CYC(PER_T)) sosc_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n),
    .i_sclk(sclk), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .i_output_disable_n(dis_n),
    .i_overtemp(overtemp), .i_supply_low(supply_low), .o_switch_outputs(outs),
    .o_common_fault_flag_n(flag_n), .o_common_fault_flag_oe_n(flag_oe_n));
  sosc_master sosc_master_inst (.o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi), .i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n),
    .o_seen(seen), .o_driven(driven));
  // Open-drain flag pin with its current source pulling up
  wire flag_pin = flag_oe_n ? 1'b1 : flag_n;
  // Clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // Next pseudo-random value
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // Compare and count
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Verdict
  task automatic end_of_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  // One frame through the master, with expectations worked out here
  task automatic run(input logic [31:0] data, input int n, input int half);
    logic [39:0] c;
    logic [31:0] m;
    m = (32'h1 << n) - 32'h1;
    c = ({32'h0, sreg} << n) | {8'h0, data & m};
    sosc_master_inst.frame(data, n, half);
    repeat (12) @(negedge i_clk);
    check("sdo stream", c[39:8] & m, seen);
    check("sdo driven", 32'h1, {31'h0, driven});
    check("sdo released", 32'h1, {31'h0, sdo_oe_n});
    sreg = c[7:0];
    if (n > 0 && n % FRAME_BITS == 0) begin
      exp_out = sreg;
      rejects = 0;
    end else begin
      rejects++;
      if (rejects >= REJECT_LIMIT) exp_out = 8'h00;
    end
    check("outputs", {24'h0, exp_out}, {24'h0, outs});
  endtask : run
  // Hang guard
  initial begin
    #1ms;
    num_errors++;
    end_of_test;
  end
  // Main sequence
  initial begin
    i_rst = 1'b1;
    dis_n = 1'b1;
    overtemp = 8'h00;
    supply_low = 1'b0;
    num_errors = 0;
    compares = 0;
    rejects = 0;
    sreg = SHIFT_RESET;
    exp_out = OUTPUTS_RESET;
    rng = 32'h45b8;
    repeat (4) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (6) @(negedge i_clk);
    check("flag idle", 32'h1, {31'h0, flag_pin});
    // Corner frames: plain, chained, slow, then four rejects in a row
    run(32'ha5, 8, 80);
    run(32'h3cc3, 16, 80);
    run(32'h5a, 8, 300);
    run(32'h0f, 7, 80);
    run(32'h1ff, 9, 80);
    run(32'h0, 0, 80);
    run(32'h6, 3, 80);
    run(32'h81, 8, 80);
    // Activity while deselected leaves everything alone
    sosc_master_inst.wiggle(11);
    repeat (12) @(negedge i_clk);
    check("deselected", {24'h0, exp_out}, {24'h0, outs});
    run(32'he7, 8, 80);
    // Random frames, valid and invalid counts
    repeat (14) begin
      rng = xs(rng);
      run(rng >> 12, (rng[1:0] == 2'h3) ? int'(rng[6:2] % 16) : 8 * (1 + int'(rng[2])), 80 + 40 * int'(rng[8]));
    end
    run(32'hff, 8, 80);
    // Disable clears outputs and the shift register, outputs stay off after release
    dis_n = 1'b0;
    repeat (10) @(negedge i_clk);
    check("disabled", 32'h0, {24'h0, outs});
    dis_n = 1'b1;
    repeat (10) @(negedge i_clk);
    check("after disable", 32'h0, {24'h0, outs});
    sreg = 8'h00;
    exp_out = 8'h00;
    rejects = 0;
    run(32'hff, 8, 80);
    // Hot channel runs at low duty, others stay on
    overtemp = 8'h04;
    repeat (10) @(negedge i_clk);
    check("flag hot", 32'h0, {31'h0, flag_pin});
    cnt = 0;
    repeat (64) begin
      @(negedge i_clk);
      cnt += int'(outs[2]);
      check("cool channels", 32'hfb, {24'h0, outs & 8'hfb});
    end
    check("low duty", 32'h1, {31'h0, cnt >= 8 && cnt <= 24});
    overtemp = 8'h00;
    repeat (40) @(negedge i_clk);
    check("restart", 32'hff, {24'h0, outs});
    check("flag cool", 32'h1, {31'h0, flag_pin});
    supply_low = 1'b1;
    repeat (10) @(negedge i_clk);
    check("flag supply", 32'h0, {31'h0, flag_pin});
    supply_low = 1'b0;
    repeat (10) @(negedge i_clk);
    check("flag back", 32'h1, {31'h0, flag_pin});
    end_of_test;
  end
endmodule : sosc_top_bench
